/* lfb_pkg.sv */
// shared constants for the logic function block: register map, op codes, timing
package lfb_pkg;
   // register byte offsets on the axi4-lite slave
   localparam int AXI_AW = 8;
   localparam logic [7:0] OFS_IN_A = 8'h00;
   localparam logic [7:0] OFS_IN_B = 8'h04;
   localparam logic [7:0] OFS_IN_C = 8'h08;
   localparam logic [7:0] OFS_OPSEL = 8'h0C;
   localparam logic [7:0] OFS_RESULT = 8'h10;
   localparam logic [7:0] OFS_STATUS = 8'h14;

   // status register fields
   localparam int STAT_FLAG_BIT = 0;
   localparam int STAT_WIN_BIT = 1;

   // axi responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // operation selector codes
   localparam int OP_W = 5;
   localparam logic [4:0] OP_MULDIV = 5'h03;
   localparam logic [4:0] OP_DECODE = 5'h05;
   localparam logic [4:0] OP_ON_DELAY = 5'h08;
   localparam logic [4:0] OP_OFF_DELAY = 5'h09;
   localparam logic [4:0] OP_TIMER = 5'h0A;
   localparam logic [4:0] OP_MIN_PULSE = 5'h0B;
   localparam logic [4:0] OP_PULSE_TRAIN = 5'h0C;
   localparam logic [4:0] OP_WINDOW = 5'h13;
   localparam logic [4:0] OP_UPDOWN = 5'h14;
   localparam logic [4:0] OP_MULDIV_RND = 5'h15;
   localparam logic [4:0] OP_WINDOW_NH = 5'h16;

   // values are signed hundredths: 1.00 is 100
   localparam logic [31:0] RST_VAL = 32'h0000_0000;
   localparam logic [4:0] RST_OPSEL = 5'h00;
   localparam logic signed [31:0] TRUE_VAL = 32'sh0000_0001;
   localparam logic signed [31:0] FALSE_VAL = 32'sh0000_0000;
   localparam logic signed [31:0] UNIT_VAL = 32'sh0000_0064;
   localparam logic signed [31:0] CNT_LIMIT = 32'sh0000_7530;
   localparam logic signed [31:0] HYST_DEFAULT = 32'sh0000_0032;

   // time base: one tick per 0.01 s
   localparam int CLK_PERIOD_NS = 25;
   localparam int TICK_PERIOD_NS = 10000000;
   localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
endpackage

/* lfb_top.sv */
// logic function block with timing ops behind an axi4-lite register slave
//
// The address map and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/100ps
module lfb_top #(
   parameter int TICK_CYCLES = lfb_pkg::TICK_CYCLES,
   parameter logic signed [31:0] HYST = lfb_pkg::HYST_DEFAULT
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic signed [31:0] result,
   output logic result_true
);
   // software-written operands and selector
   logic signed [31:0] in_a;
   logic signed [31:0] in_b;
   logic signed [31:0] in_c;
   logic [4:0] opsel;
   logic [4:0] op_q;
   // write channel holding state
   logic aw_held;
   logic w_held;
   logic [7:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   // timing state
   logic [31:0] tick_cnt;
   logic tick;
   logic [31:0] tmr;
   logic flag;
   logic signed [31:0] cnt;
   logic a_prev;
   logic b_prev;
   logic win_in_q;
   logic [31:0] next_tmr;
   logic next_flag;
   logic signed [31:0] next_cnt;
   logic signed [31:0] next_result;

   // ---------------- axi4-lite write path ----------------
   wire aw_hs = s_axi_awvalid & s_axi_awready;
   wire w_hs = s_axi_wvalid & s_axi_wready;
   wire wr_do = aw_held & w_held & ~s_axi_bvalid;
   wire next_aw_held = (aw_held & ~wr_do) | aw_hs;
   wire next_w_held = (w_held & ~wr_do) | w_hs;
   wire sel_a = (aw_addr_q == lfb_pkg::OFS_IN_A);
   wire sel_b = (aw_addr_q == lfb_pkg::OFS_IN_B);
   wire sel_c = (aw_addr_q == lfb_pkg::OFS_IN_C);
   wire sel_op = (aw_addr_q == lfb_pkg::OFS_OPSEL);
   wire wr_ok = sel_a | sel_b | sel_c | sel_op;

   // merge write data into an old value by byte strobes
   function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] dat,
                                          input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[8*i +: 8] = dat[8*i +: 8];
         end
      end
      return res;
   endfunction

   wire [31:0] op_merged = wmerge({27'h0, opsel}, w_data_q, w_strb_q);

   // channel acceptance; one address and one data word held at most
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
      end else begin
         aw_held <= next_aw_held;
         w_held <= next_w_held;
         s_axi_awready <= ~next_aw_held;
         s_axi_wready <= ~next_w_held;
      end
   end

   // capture payloads when taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_addr_q <= lfb_pkg::RST_VAL[7:0];
         w_data_q <= lfb_pkg::RST_VAL;
         w_strb_q <= lfb_pkg::RST_VAL[3:0];
      end else begin
         if (aw_hs) aw_addr_q <= s_axi_awaddr;
         if (w_hs) w_data_q <= s_axi_wdata;
         if (w_hs) w_strb_q <= s_axi_wstrb;
      end
   end

   // write response; read-only and unmapped words answer slverr
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= lfb_pkg::RESP_OKAY;
      end else if (wr_do) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_ok ? lfb_pkg::RESP_OKAY : lfb_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // operand registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         in_a <= lfb_pkg::RST_VAL;
         in_b <= lfb_pkg::RST_VAL;
         in_c <= lfb_pkg::RST_VAL;
         opsel <= lfb_pkg::RST_OPSEL;
      end else if (wr_do) begin
         if (sel_a) in_a <= wmerge(in_a, w_data_q, w_strb_q);
         if (sel_b) in_b <= wmerge(in_b, w_data_q, w_strb_q);
         if (sel_c) in_c <= wmerge(in_c, w_data_q, w_strb_q);
         if (sel_op) opsel <= op_merged[4:0];
      end
   end

   // ---------------- axi4-lite read path ----------------
   wire ar_hs = s_axi_arvalid & s_axi_arready;
   wire next_rvalid = (s_axi_rvalid & ~s_axi_rready) | ar_hs;
   wire rd_a = (s_axi_araddr == lfb_pkg::OFS_IN_A);
   wire rd_b = (s_axi_araddr == lfb_pkg::OFS_IN_B);
   wire rd_c = (s_axi_araddr == lfb_pkg::OFS_IN_C);
   wire rd_op = (s_axi_araddr == lfb_pkg::OFS_OPSEL);
   wire rd_res = (s_axi_araddr == lfb_pkg::OFS_RESULT);
   wire rd_st = (s_axi_araddr == lfb_pkg::OFS_STATUS);
   wire rd_ok = rd_a | rd_b | rd_c | rd_op | rd_res | rd_st;
   wire [31:0] status_word = (32'(flag) << lfb_pkg::STAT_FLAG_BIT)
                           | (32'(win_in_q) << lfb_pkg::STAT_WIN_BIT);
   wire [31:0] rd_mux = rd_a ? in_a :
                        rd_b ? in_b :
                        rd_c ? in_c :
                        rd_op ? {27'h0, opsel} :
                        rd_res ? result :
                        rd_st ? status_word : lfb_pkg::RST_VAL;

   // read answer one cycle after the address is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= lfb_pkg::RST_VAL;
         s_axi_rresp <= lfb_pkg::RESP_OKAY;
      end else begin
         s_axi_arready <= ~next_rvalid;
         s_axi_rvalid <= next_rvalid;
         if (ar_hs) s_axi_rdata <= rd_mux;
         if (ar_hs) s_axi_rresp <= rd_ok ? lfb_pkg::RESP_OKAY : lfb_pkg::RESP_SLVERR;
      end
   end

   // ---------------- time base ----------------
   // 0.01 s tick so durations in hundredths map one to one onto ticks
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tick_cnt <= lfb_pkg::RST_VAL;
         tick <= 1'b0;
      end else if (tick_cnt >= 32'(TICK_CYCLES - 1)) begin
         tick_cnt <= lfb_pkg::RST_VAL;
         tick <= 1'b1;
      end else begin
         tick_cnt <= tick_cnt + 32'h1;
         tick <= 1'b0;
      end
   end

   // ---------------- operand decode ----------------
   wire a_t = (in_a != lfb_pkg::FALSE_VAL);
   wire b_t = (in_b != lfb_pkg::FALSE_VAL);
   wire c_t = (in_c != lfb_pkg::FALSE_VAL);
   wire a_rise = a_t & ~a_prev;
   wire b_rise = b_t & ~b_prev;
   wire op_chg = (opsel != op_q);
   // negative durations count as already expired
   wire [31:0] b_dur = in_b[31] ? 32'h0 : in_b;
   wire [31:0] c_dur = in_c[31] ? 32'h0 : in_c;
   wire [31:0] tmr_inc = (tick && tmr != 32'h7FFF_FFFF) ? tmr + 32'h1 : tmr;

   // ---------------- window comparator ----------------
   // 34-bit arithmetic keeps bounds from wrapping near full scale
   wire signed [33:0] a_x = {{2{in_a[31]}}, in_a};
   wire signed [33:0] b_x = {{2{in_b[31]}}, in_b};
   wire signed [33:0] c_x = {{2{in_c[31]}}, in_c};
   wire signed [33:0] c_abs = in_c[31] ? -c_x : c_x;
   wire signed [33:0] half_rng = c_abs >>> 1;
   wire widen_on = win_in_q & (opsel == lfb_pkg::OP_WINDOW);
   wire signed [33:0] widen = widen_on ? {{2{HYST[31]}}, HYST} : 34'sh0;
   wire signed [33:0] win_lo = b_x - half_rng - widen;
   wire signed [33:0] win_hi = b_x + half_rng + widen;
   wire win_hit = c_t ? (a_x >= win_lo && a_x <= win_hi) : (in_a == in_b);
   wire win_out = win_hit ^ in_c[31];
   wire is_win = (opsel == lfb_pkg::OP_WINDOW) | (opsel == lfb_pkg::OP_WINDOW_NH);

   // ---------------- multiply-divide ----------------
   // hundredths scale cancels: a*b/c stays in hundredths
   wire signed [63:0] prod = 64'(in_a) * 64'(in_b);
   wire [63:0] prod_abs = prod[63] ? 64'(-prod) : 64'(prod);
   wire [63:0] div_abs = {32'h0, c_abs[31:0]};
   wire rnd = (opsel == lfb_pkg::OP_MULDIV_RND);
   wire [63:0] rnd_add = rnd ? (div_abs >> 1) : 64'h0;
   // division by zero returns zero rather than a trap value
   wire [63:0] quo_abs = c_t ? (prod_abs + rnd_add) / div_abs : 64'h0;
   wire quo_neg = prod[63] ^ in_c[31];
   wire quo_big = (quo_abs > 64'h0000_0000_7FFF_FFFF);
   wire [31:0] quo_sat = quo_big ? 32'h7FFF_FFFF : quo_abs[31:0];
   wire signed [31:0] md_val = quo_neg ? -$signed(quo_sat) : $signed(quo_sat);

   // ---------------- decode ----------------
   wire [2:0] dec_bits = {c_t, b_t, a_t};
   wire signed [31:0] dec_val = 32'($signed({29'h0, dec_bits}) * lfb_pkg::UNIT_VAL);

   // ---------------- up/down counter ----------------
   wire signed [31:0] cnt_up = (cnt < lfb_pkg::CNT_LIMIT) ? cnt + lfb_pkg::UNIT_VAL : cnt;
   wire signed [31:0] cnt_dn = (cnt > -lfb_pkg::CNT_LIMIT) ? cnt - lfb_pkg::UNIT_VAL : cnt;

   always_comb begin
      next_cnt = cnt;
      if (op_chg || opsel != lfb_pkg::OP_UPDOWN || c_t) begin
         next_cnt = lfb_pkg::FALSE_VAL;
      end else if (a_rise && !b_rise) begin
         next_cnt = cnt_up;
      end else if (b_rise && !a_rise) begin
         next_cnt = cnt_dn;
      end
   end

   // ---------------- timer state per operation ----------------
   always_comb begin
      next_tmr = tmr;
      next_flag = flag;
      if (op_chg) begin
         next_tmr = 32'h0;
         next_flag = 1'b0;
      end else begin
         unique case (opsel)
            lfb_pkg::OP_ON_DELAY: begin
               if (!a_t) begin
                  next_tmr = 32'h0;
                  next_flag = 1'b0;
               end else begin
                  next_tmr = tmr_inc;
                  next_flag = (tmr >= b_dur);
               end
            end
            lfb_pkg::OP_OFF_DELAY: begin
               if (a_t) begin
                  next_tmr = 32'h0;
                  next_flag = 1'b1;
               end else begin
                  next_tmr = tmr_inc;
                  if (tmr >= b_dur) next_flag = 1'b0;
               end
            end
            lfb_pkg::OP_TIMER: begin
               if (b_t) begin
                  next_tmr = tmr;
               end else if (a_t) begin
                  next_tmr = tmr_inc;
               end else begin
                  next_tmr = 32'h0;
               end
            end
            lfb_pkg::OP_MIN_PULSE: begin
               if (a_rise) begin
                  next_tmr = 32'h0;
                  next_flag = 1'b1;
               end else if (a_t) begin
                  next_tmr = tmr_inc;
                  next_flag = 1'b1;
               end else if (flag) begin
                  next_tmr = tmr_inc;
                  if (tmr >= b_dur) next_flag = 1'b0;
               end
            end
            lfb_pkg::OP_PULSE_TRAIN: begin
               if (!a_t) begin
                  next_tmr = 32'h0;
                  next_flag = 1'b1;
               end else if (tmr >= (flag ? b_dur : c_dur)) begin
                  next_tmr = 32'h0;
                  next_flag = ~flag;
               end else begin
                  next_tmr = tmr_inc;
               end
            end
            default: begin
               next_tmr = 32'h0;
               next_flag = 1'b0;
            end
         endcase
      end
   end

   // boolean to output value
   function automatic logic signed [31:0] bval(input logic t);
      return t ? lfb_pkg::TRUE_VAL : lfb_pkg::FALSE_VAL;
   endfunction

   // ---------------- result select ----------------
   always_comb begin
      unique case (opsel)
         lfb_pkg::OP_DECODE: next_result = dec_val;
         lfb_pkg::OP_ON_DELAY: next_result = bval(flag ^ c_t);
         lfb_pkg::OP_OFF_DELAY: next_result = bval(flag ^ c_t);
         lfb_pkg::OP_TIMER: next_result = $signed(tmr);
         lfb_pkg::OP_MIN_PULSE: next_result = bval(flag ^ c_t);
         lfb_pkg::OP_PULSE_TRAIN: next_result = bval(flag & a_t);
         lfb_pkg::OP_WINDOW: next_result = bval(win_out);
         lfb_pkg::OP_WINDOW_NH: next_result = bval(win_out);
         lfb_pkg::OP_UPDOWN: next_result = cnt;
         lfb_pkg::OP_MULDIV: next_result = md_val;
         lfb_pkg::OP_MULDIV_RND: next_result = md_val;
         default: next_result = lfb_pkg::FALSE_VAL;
      endcase
   end

   // state registers; edges are seen against the previous cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tmr <= lfb_pkg::RST_VAL;
         flag <= 1'b0;
         cnt <= lfb_pkg::FALSE_VAL;
         a_prev <= 1'b0;
         b_prev <= 1'b0;
         op_q <= lfb_pkg::RST_OPSEL;
         win_in_q <= 1'b0;
      end else begin
         tmr <= next_tmr;
         flag <= next_flag;
         cnt <= next_cnt;
         a_prev <= a_t;
         b_prev <= b_t;
         op_q <= opsel;
         win_in_q <= is_win & win_hit;
      end
   end

   // outputs registered for clean timing to the consumer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         result <= lfb_pkg::FALSE_VAL;
         result_true <= 1'b0;
      end else begin
         result <= next_result;
         result_true <= (next_result != lfb_pkg::FALSE_VAL);
      end
   end
endmodule

/* lfb_checker.sv */
// concurrent checks on the bus handshake and result ports of the function block
`timescale 1ns/100ps
module lfb_checker (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic signed [31:0] result,
   input wire logic result_true
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // a fresh write: both halves taken at once with no answer pending
   sequence s_wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid;
   endsequence
   sequence s_rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   a_wr_latency: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
      else $error("write answer not on time");
   a_wr_busy: assert property (s_wr_taken |=> !s_axi_awready && !s_axi_wready)
      else $error("write channels still ready while busy");
   a_rd_latency: assert property (s_rd_taken |=> s_axi_rvalid && !s_axi_arready)
      else $error("read answer not on time");
   a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped early");
   a_r_hold: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
      else $error("read answer dropped early");
   a_r_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
      else $error("read answer not released");
   a_true_flag: assert property (result_true == (result != 32'sh0))
      else $error("true flag disagrees with result");
   a_reset_idle: assert property ($rose(aresetn)
      |-> s_axi_awready && s_axi_arready && !s_axi_bvalid && !s_axi_rvalid && result == 32'sh0)
      else $error("ports not idle after reset");
   a_resp_code: assert property (s_axi_bvalid |-> s_axi_bresp inside {2'h0, 2'h2})
      else $error("illegal write response code");
endmodule
bind lfb_top lfb_checker u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
   .s_axi_rready, .result, .result_true);

/* lfb_sink.sv */
// downstream consumer of the block output: counts rising edges of the true flag
`timescale 1ns/100ps
module lfb_sink (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic result_true,
   output int rises
);
   logic last;
   // edge count lets the bench judge pulse trains without matching phases
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         last <= 1'b0;
         rises <= 0;
      end else begin
         last <= result_true;
         if (result_true && !last) rises <= rises + 1;
      end
   end
endmodule

/* tb.sv */
// self-checking bench: register access over the bus and function scenarios
`timescale 1ns/100ps
module tb;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   wire awready, wready, bvalid, arready, rvalid, rt;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire signed [31:0] result;
   int n_mismatch = 0, checks = 0, cyc = 0, rises, r0;
   logic [1:0] rsp;
   logic [31:0] v;
   // op, a, b, c, expected result
   logic [31:0] tb_t [13][5] = '{'{32'h13, 32'h12C, 32'h1F4, 32'h190, 32'h1},
      '{32'h13, 32'h2EE, 32'h1F4, 32'h190, 32'h1}, '{32'h13, 32'h2F8, 32'h1F4, 32'h190, 32'h0},
      '{32'h13, 32'h104, 32'h1F4, 32'h190, 32'h0}, '{32'h16, 32'h12C, 32'h1F4, 32'h190, 32'h1},
      '{32'h16, 32'h2EE, 32'h1F4, 32'h190, 32'h0}, '{32'h16, 32'h1F4, 32'h1F4, 32'h0, 32'h1},
      '{32'h16, 32'h1F5, 32'h1F4, 32'h0, 32'h0}, '{32'h13, 32'h1F4, 32'h1F4, 32'hFFFFFE70, 32'h0},
      '{32'h13, 32'h384, 32'h1F4, 32'hFFFFFE70, 32'h1}, '{32'h3, 32'h7, 32'h1, 32'h2, 32'h3},
      '{32'h15, 32'h7, 32'h1, 32'h2, 32'h4}, '{32'h15, 32'hFFFFFFF9, 32'h1, 32'h2, 32'hFFFFFFFC}};

   // short tick so a one-second count stays inside the run budget
   lfb_top #(.TICK_CYCLES(4)) DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .result(result), .result_true(rt));
   lfb_sink u_sink (.aclk(aclk), .aresetn(aresetn), .result_true(rt), .rises(rises));

   always #12.5 aclk = ~aclk;
   // hang guard
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         n_mismatch++;
         summarize();
      end
   end

   task automatic summarize();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("mismatch %s expected %0h seen %0h", nm, e, g);
      end
   endtask
   // address and data offered together, each released once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ad, dd;
      ad = 1'b0;
      dd = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!(ad && dd)) begin
         @(posedge aclk);
         if (awvalid && awready) begin
            ad = 1'b1;
            awvalid <= 1'b0;
         end
         if (wvalid && wready) begin
            dd = 1'b1;
            wvalid <= 1'b0;
         end
      end
      // answer left waiting one cycle so the slave must hold it
      do @(posedge aclk); while (!bvalid);
      bready <= 1'b1;
      @(posedge aclk);
      rsp = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge aclk); while (!rvalid);
      rready <= 1'b1;
      @(posedge aclk);
      v = rdata;
      rsp = rresp;
      rready <= 1'b0;
   endtask
   task automatic put(input logic [31:0] a, input logic [31:0] b, input logic [31:0] c);
      wr(lfb_pkg::OFS_IN_A, a);
      wr(lfb_pkg::OFS_IN_B, b);
      wr(lfb_pkg::OFS_IN_C, c);
   endtask
   task automatic res(input int w, input logic [31:0] e);
      repeat (w) @(posedge aclk);
      chk("result", e, result);
   endtask

   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(lfb_pkg::OFS_OPSEL);
      chk("opsel reset", 32'h0, v);
      rd(8'h20);
      chk("unmapped read", {30'h0, lfb_pkg::RESP_SLVERR}, {30'h0, rsp});
      wr(lfb_pkg::OFS_RESULT, 32'h1);
      chk("read-only write", {30'h0, lfb_pkg::RESP_SLVERR}, {30'h0, rsp});
      wr(lfb_pkg::OFS_IN_C, 32'hFFFFFFFF);
      rd(lfb_pkg::OFS_IN_C);
      chk("in_c readback", 32'hFFFFFFFF, v);
      wr(lfb_pkg::OFS_OPSEL, {27'h0, lfb_pkg::OP_DECODE});
      for (int i = 0; i < 8; i++) begin
         put({31'h0, i[0]}, {30'h0, i[1], 1'b0}, {29'h0, i[2], 2'h0});
         res(6, 32'h64 * i);
      end
      // op changes only when it differs, so window state carries between rows
      for (int i = 0; i < 13; i++) begin
         if (i == 0 || tb_t[i][0] != tb_t[i-1][0]) wr(lfb_pkg::OFS_OPSEL, tb_t[i][0]);
         put(tb_t[i][1], tb_t[i][2], tb_t[i][3]);
         res(6, tb_t[i][4]);
      end
      // on-delay and off-delay, plain and inverted, 0.1 s delay
      for (int k = 0; k < 4; k++) begin
         wr(lfb_pkg::OFS_OPSEL, (k < 2) ? 32'h8 : 32'h9);
         put({31'h0, k[1]}, 32'hA, {31'h0, k[0]});
         res(80, {31'h0, k[1] ^ k[0]});
         wr(lfb_pkg::OFS_IN_A, {31'h0, !k[1]});
         res(20, {31'h0, k[1] ^ k[0]});
         res(60, {31'h0, !(k[1] ^ k[0])});
      end
      wr(lfb_pkg::OFS_OPSEL, {27'h0, lfb_pkg::OP_MIN_PULSE});
      put(32'h0, 32'h14, 32'h0);
      wr(lfb_pkg::OFS_IN_A, 32'h1);
      wr(lfb_pkg::OFS_IN_A, 32'h0);
      res(20, 32'h1);
      res(100, 32'h0);
      wr(lfb_pkg::OFS_IN_C, 32'h1);
      res(6, 32'h1);
      wr(lfb_pkg::OFS_OPSEL, {27'h0, lfb_pkg::OP_TIMER});
      put(32'h64, 32'h0, 32'h7);
      repeat (200) @(posedge aclk);
      wr(lfb_pkg::OFS_IN_B, 32'h1);
      repeat (6) @(posedge aclk);
      v = result;
      chk("timer span", 32'h1, {31'h0, v >= 32'h28 && v <= 32'h3C});
      res(100, v);
      wr(lfb_pkg::OFS_IN_B, 32'h0);
      repeat (40) @(posedge aclk);
      chk("timer resumed", 32'h1, {31'h0, result > v});
      wr(lfb_pkg::OFS_IN_A, 32'h0);
      res(6, 32'h0);
      wr(lfb_pkg::OFS_OPSEL, {27'h0, lfb_pkg::OP_PULSE_TRAIN});
      put(32'h0, 32'h5, 32'h5);
      r0 = rises;
      res(100, 32'h0);
      chk("train idle", r0, rises);
      wr(lfb_pkg::OFS_IN_A, 32'h1);
      repeat (400) @(posedge aclk);
      chk("train pulses", 32'h1, {31'h0, rises - r0 >= 5 && rises - r0 <= 12});
      wr(lfb_pkg::OFS_OPSEL, {27'h0, lfb_pkg::OP_UPDOWN});
      put(32'h0, 32'h0, 32'h0);
      for (int i = 0; i < 3; i++) begin
         wr(lfb_pkg::OFS_IN_A, 32'h1);
         wr(lfb_pkg::OFS_IN_A, 32'h0);
      end
      wr(lfb_pkg::OFS_IN_B, 32'h1);
      res(6, 32'hC8);
      for (int i = 0; i < 300; i++) begin
         wr(lfb_pkg::OFS_IN_A, 32'h1);
         wr(lfb_pkg::OFS_IN_A, 32'h0);
      end
      res(6, lfb_pkg::CNT_LIMIT);
      wr(lfb_pkg::OFS_IN_C, 32'h64);
      res(6, 32'h0);
      summarize();
   end
endmodule
